// ---- count_link_if.sv ----
// carrier between the timer control logic and one down counter
`timescale 1ns/1ps
interface count_link_if #(
	parameter int WIDTH = 16
);
	logic load;                // take load_value this cycle
	logic [WIDTH-1:0] load_value; // value to load
	logic step;                // decrement by one this cycle
	logic [WIDTH-1:0] value;   // current count
	logic at_zero;             // count is zero

	// control side drives commands and watches the count
	modport control (output load, output load_value, output step, input value, input at_zero);
	// counter side keeps the count
	modport counter (input load, input load_value, input step, output value, output at_zero);
endinterface

// ---- cpu_bus_model.sv ----
// processor model that drives the register-select bus of the timer
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic i_mclk,         // system clock
	output logic [3:0] o_reg_select, // register select lines
	output logic o_access,           // access strobe, one cycle
	output logic o_read,             // high for read, low for write
	output logic [7:0] o_data,       // write data
	input wire logic [7:0] i_data    // read data from the timer
);
	// idle bus at time zero: no strobe
	initial begin
		o_reg_select = 4'h0;
		o_access = 1'b0;
		o_read = 1'b1;
		o_data = 8'h00;
	end

	// drop the strobe; lines no longer carry the last value
	task automatic drop_bus(input logic [3:0] sel, input logic [7:0] val);
		o_access <= 1'b0;
		o_reg_select <= ~sel;
		o_data <= ~val;
	endtask

	// one write: driven after an edge, taken at the next
	task automatic wr(input logic [3:0] sel, input logic [7:0] val);
		@(posedge i_mclk);
		o_reg_select <= sel;
		o_read <= 1'b0;
		o_data <= val;
		o_access <= 1'b1;
		@(posedge i_mclk);
		drop_bus(sel, val);
	endtask

	// one read: data is picked up once the registered answer has settled
	task automatic rd(input logic [3:0] sel, output logic [7:0] val);
		@(posedge i_mclk);
		o_reg_select <= sel;
		o_read <= 1'b1;
		o_access <= 1'b1;
		@(posedge i_mclk);
		drop_bus(sel, o_data);
		@(posedge i_mclk);
		#1;
		val = i_data;
	endtask
endmodule

// ---- down_counter.sv ----
// loadable down counter shared by both timers
`timescale 1ns/1ps
`include "dual_interval_timer_cfg.svh"
module down_counter #(
	parameter int WIDTH = `COUNT_WIDTH
) (
	input wire logic i_mclk,       // system clock
	input wire logic i_rst_n,      // asynchronous reset, active low
	count_link_if.counter link     // load, step and count
);
	// the counter state, one packed word
	typedef struct packed {
		logic [WIDTH-1:0] value; // present count
	} count_state_type;

	count_state_type s_q;
	count_state_type s_d;

	// load has priority over a step; zero wraps to all ones
	always_comb begin
		s_d = s_q;
		if (link.load) begin
			s_d.value = link.load_value;
		end else if (link.step) begin
			s_d.value = s_q.value - WIDTH'(1);
		end
	end

	// register the state
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q.value <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.value = s_q.value;
	assign link.at_zero = (s_q.value == '0);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// a load always wins over a step
	count_load_a: assert property (link.load |=> link.value == $past(link.load_value))
		else $error("counter did not take its load value");
	// a step alone lowers the count by exactly one
	count_step_a: assert property (link.step && !link.load |=> link.value == $past(link.value) - WIDTH'(1))
		else $error("counter step did not lower the count by one");
endmodule

// ---- dual_interval_timer.sv ----
// two 16-bit interval timers reached through register-select lines
//
// Overview of operation
// - high count write loads, clears, starts timer
// - low count byte never written directly
// - latch-only writes; high latch clears flag
// - reads return counters, latches; low clears
// - two control bits pick four modes
// - first counter decrements every clock once started
// - one-shot zero sets flag, irq, pin high
// - one-shot output: pin low after high write
// - pin driven by direction or output enable
// - one-shot high latch write leaves count and pin
// - free-run zero: flag, invert pin, reload
// - free-run flag sets each timeout; four clears
// - high write retriggers; latches at reload
// - one bit selects interval or pulse count
// - second timer low latch, read, high load
// - second counter decrements every clock interval
// - second flag once per high write
// - pulse mode counts falling count pin edges
`timescale 1ns/1ps
`include "dual_interval_timer_cfg.svh"
module dual_interval_timer (
	input wire logic i_mclk,                   // system clock, 100 MHz
	input wire logic i_rst_n,                  // asynchronous reset, active low
	input wire logic [3:0] i_reg_select,       // register select lines
	input wire logic i_access,                 // one-cycle strobe: chip selected access
	input wire logic i_read,                   // high for read, low for write
	input wire logic [7:0] i_data,             // write data
	output logic [7:0] o_data,                 // read data, registered
	input wire logic i_wave_output_enable,     // first timer drives the wave pin
	input wire logic i_free_run_enable,        // first timer free-running
	input wire logic i_second_pulse_mode,      // second timer counts pin pulses
	input wire logic i_wave_pin_direction,     // port direction bit of the wave pin
	input wire logic i_wave_pin_out_value,     // port output bit of the wave pin
	input wire logic i_first_flag_clear,       // one-cycle direct clear of first flag
	input wire logic i_first_irq_enable,       // first flag may interrupt
	input wire logic i_second_irq_enable,      // second flag may interrupt
	input wire logic i_pulse_count_pin,        // count pin, sampled each clock
	output logic o_timer_wave_pin,             // wave pin output level
	output logic o_timer_wave_pin_oe_n,        // wave pin enable, low while driven
	output logic o_interrupt_request_n,        // interrupt request, active low
	output logic o_first_flag,                 // first timer flag
	output logic o_second_flag                 // second timer flag
);
	dual_interval_timer_pkg::timer_state_type s_q; // registered state
	dual_interval_timer_pkg::timer_state_type s_d; // next state

	count_link_if #(.WIDTH(`COUNT_WIDTH)) first_link();  // first timer counter
	count_link_if #(.WIDTH(`COUNT_WIDTH)) second_link(); // second timer counter

	// select decode, used for the strobes and clear terms
	function automatic logic sel_hit(input logic [3:0] sel, input logic [3:0] off);
		return sel == off;
	endfunction

	logic wr;             // write strobe
	logic rd;             // read strobe
	logic wr_first_high;  // high count write of the first timer
	logic wr_second_high; // high count write of the second timer
	logic first_timeout;  // first counter running and at zero
	logic first_set;      // first flag set event
	logic first_clear;    // first flag clear event
	logic pulse_fall;     // falling edge on the count pin
	logic second_step;    // second counter steps this cycle
	logic second_timeout; // second counter steps out of zero
	logic second_set;     // second flag set event
	logic second_clear;   // second flag clear event

	// access strobes
	assign wr = i_access && !i_read;
	assign rd = i_access && i_read;
	assign wr_first_high = wr && sel_hit(i_reg_select, `OFF_FIRST_COUNT_HIGH);
	assign wr_second_high = wr && sel_hit(i_reg_select, `OFF_SECOND_COUNT_HIGH);

	// first timer events
	assign first_timeout = s_q.first_run && first_link.at_zero;
	assign first_set = first_timeout && (i_free_run_enable || s_q.first_armed);
	// high count or high latch write, low count read or direct clear clears the flag
	assign first_clear = (wr && (sel_hit(i_reg_select, `OFF_FIRST_COUNT_HIGH)
		|| sel_hit(i_reg_select, `OFF_FIRST_LATCH_HIGH)))
		|| (rd && sel_hit(i_reg_select, `OFF_FIRST_COUNT_LOW))
		|| i_first_flag_clear;

	// high count write loads both bytes
	// low byte comes only from the latch
	// free-run timeout reloads from both latches
	assign first_link.load = wr_first_high || (first_timeout && i_free_run_enable);
	assign first_link.load_value = wr_first_high ? {i_data, s_q.first_latch_low}
		: {s_q.first_latch_high, s_q.first_latch_low};
	// one step per clock once started
	assign first_link.step = s_q.first_run;

	// second timer events
	// negative pulse seen as a high-to-low change
	assign pulse_fall = s_q.pulse_prev && !i_pulse_count_pin;
	// mode bit chooses the step source
	assign second_step = s_q.second_run && (i_second_pulse_mode ? pulse_fall : 1'b1);
	assign second_timeout = second_step && second_link.at_zero;
	// flag sets only once per high write
	assign second_set = second_timeout && s_q.second_armed;
	assign second_clear = wr_second_high || (rd && sel_hit(i_reg_select, `OFF_SECOND_COUNT_LOW));

	// high write copies the low latch in
	assign second_link.load = wr_second_high;
	assign second_link.load_value = {i_data, s_q.second_latch_low};
	assign second_link.step = second_step;

	// next-state logic for latches, flags, wave and read data
	always_comb begin
		s_d = s_q;
		s_d.pulse_prev = i_pulse_count_pin;
		if (wr) begin
			unique case (i_reg_select)
				`OFF_FIRST_COUNT_LOW, `OFF_FIRST_LATCH_LOW: begin
					s_d.first_latch_low = i_data;
				end
				// high count write also fills high latch
				`OFF_FIRST_COUNT_HIGH: begin
					s_d.first_latch_high = i_data;
				end
				// latch only, the countdown is untouched
				`OFF_FIRST_LATCH_HIGH: begin
					s_d.first_latch_high = i_data;
				end
				`OFF_SECOND_COUNT_LOW: begin
					s_d.second_latch_low = i_data;
				end
				// second high count and unmapped codes store no latch
				default: begin
				end
			endcase
		end
		if (rd) begin
			unique case (i_reg_select)
				`OFF_FIRST_COUNT_LOW: s_d.read_data = first_link.value[7:0];
				`OFF_FIRST_COUNT_HIGH: s_d.read_data = first_link.value[15:8];
				`OFF_FIRST_LATCH_LOW: s_d.read_data = s_q.first_latch_low;
				`OFF_FIRST_LATCH_HIGH: s_d.read_data = s_q.first_latch_high;
				`OFF_SECOND_COUNT_LOW: s_d.read_data = second_link.value[7:0];
				`OFF_SECOND_COUNT_HIGH: s_d.read_data = second_link.value[15:8];
				default: s_d.read_data = `RST_BYTE;
			endcase
		end
		// a high count write restarts the period
		if (wr_first_high) begin
			s_d.first_run = 1'b1;
			s_d.first_armed = 1'b1;
		end else if (first_timeout && !i_free_run_enable) begin
			// one-shot disarms after the first zero
			s_d.first_armed = 1'b0;
		end
		// flag: set wins over clear
		s_d.first_flag = first_set || (s_q.first_flag && !first_clear);
		// wave level of the first timer
		if (wr_first_high) begin
			// pulse starts low after the load
			s_d.wave = 1'b0;
		end else if (first_timeout && i_free_run_enable) begin
			s_d.wave = !s_q.wave;
		end else if (first_timeout && s_q.first_armed) begin
			s_d.wave = 1'b1;
		end
		// second timer control
		if (wr_second_high) begin
			s_d.second_run = 1'b1;
			s_d.second_armed = 1'b1;
		end else if (second_timeout) begin
			s_d.second_armed = 1'b0;
		end
		s_d.second_flag = second_set || (s_q.second_flag && !second_clear);
	end

	// register the state
	// flags, run bits and wave idle after reset
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q.first_latch_low <= `RST_BYTE;
			s_q.first_latch_high <= `RST_BYTE;
			s_q.first_run <= 1'b0;
			s_q.first_armed <= 1'b0;
			s_q.first_flag <= 1'b0;
			s_q.wave <= `RST_WAVE;
			s_q.second_latch_low <= `RST_BYTE;
			s_q.second_run <= 1'b0;
			s_q.second_armed <= 1'b0;
			s_q.second_flag <= 1'b0;
			s_q.pulse_prev <= 1'b1;
			s_q.read_data <= `RST_BYTE;
		end else begin
			s_q <= s_d;
		end
	end

	// the two counters
	down_counter #(.WIDTH(`COUNT_WIDTH)) first_counter (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.link(first_link)
	);
	down_counter #(.WIDTH(`COUNT_WIDTH)) second_counter (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.link(second_link)
	);

	// outputs
	assign o_data = s_q.read_data;
	assign o_first_flag = s_q.first_flag;
	assign o_second_flag = s_q.second_flag;
	// enabled flags pull the request low
	assign o_interrupt_request_n = !((s_q.first_flag && i_first_irq_enable)
		|| (s_q.second_flag && i_second_irq_enable));
	// output enable bit hands the pin to the timer
	// either bit makes the pin an output
	assign o_timer_wave_pin = i_wave_output_enable ? s_q.wave : i_wave_pin_out_value;
	assign o_timer_wave_pin_oe_n = !(i_wave_pin_direction || i_wave_output_enable);

	default clocking main_cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	first_load_a: assert property (wr_first_high |=>
		first_link.value == {$past(i_data), $past(s_q.first_latch_low)} && s_q.first_run
		&& (s_q.first_flag == $past(first_set)))
		else $error("high count write did not load and start the first timer");
	latch_only_a: assert property (wr && sel_hit(i_reg_select, `OFF_FIRST_LATCH_HIGH)
		&& !first_set |=> !s_q.first_flag && s_q.first_latch_high == $past(i_data))
		else $error("high latch write did not store or did not clear the flag");
	low_read_a: assert property (rd && sel_hit(i_reg_select, `OFF_FIRST_COUNT_LOW)
		|=> o_data == $past(first_link.value[7:0]) && (o_first_flag == $past(first_set)))
		else $error("low count read returned wrong byte or left the flag");
	first_decrement_a: assert property (s_q.first_run && !first_link.load
		|=> first_link.value == $past(first_link.value) - 16'h0001)
		else $error("first counter did not decrement by one");
	oneshot_end_a: assert property (first_timeout && !i_free_run_enable && s_q.first_armed
		&& !wr_first_high |=> s_q.first_flag && s_q.wave ##1 (!s_q.first_armed || $past(wr_first_high)))
		else $error("one-shot timeout did not raise flag and wave");
	pulse_start_a: assert property (wr_first_high ##1 !first_timeout
		|-> !s_q.wave)
		else $error("wave did not go low after the high count write");
	pin_owner_a: assert property (o_timer_wave_pin_oe_n == !(i_wave_pin_direction
		|| i_wave_output_enable) && (!i_wave_output_enable || o_timer_wave_pin == s_q.wave))
		else $error("wave pin enable or source is wrong");
	latch_quiet_a: assert property (wr && sel_hit(i_reg_select, `OFF_FIRST_LATCH_HIGH)
		&& s_q.first_run && !first_timeout
		|=> $stable(s_q.wave) && first_link.value == $past(first_link.value) - 16'h0001)
		else $error("high latch write disturbed the countdown");
	free_reload_a: assert property (first_timeout && i_free_run_enable && !wr_first_high
		|=> first_link.value == $past({s_q.first_latch_high, s_q.first_latch_low})
		&& s_q.wave != $past(s_q.wave) && s_q.first_flag)
		else $error("free-run timeout did not reload, toggle and flag");
	second_load_a: assert property (wr_second_high |=> second_link.value
		== {$past(i_data), $past(s_q.second_latch_low)} && s_q.second_armed)
		else $error("second timer high write did not load");
	second_once_a: assert property (second_timeout && !wr_second_high
		|=> !s_q.second_armed ##1 (s_q.second_flag == $past(s_q.second_flag)) || $past(second_clear))
		else $error("second flag stayed armed after a timeout");
	pulse_hold_a: assert property (i_second_pulse_mode && !pulse_fall && !wr_second_high
		|=> $stable(second_link.value))
		else $error("second counter moved without a count pin pulse");

	oneshot_c: cover property (wr_first_high ##[1:40] first_timeout && !i_free_run_enable);
	free_run_c: cover property (first_timeout && i_free_run_enable ##[1:40] first_timeout);
	pulse_count_c: cover property (i_second_pulse_mode && second_timeout && s_q.second_armed);
	retrigger_c: cover property (wr_first_high ##[1:8] wr_first_high);
endmodule

// ---- dual_interval_timer_cfg.svh ----
// register offsets, reset values and widths of the dual interval timer
`ifndef DUAL_INTERVAL_TIMER_CFG_SVH
`define DUAL_INTERVAL_TIMER_CFG_SVH

// select codes on the four register-select lines
`define OFF_FIRST_COUNT_LOW 4'h4
`define OFF_FIRST_COUNT_HIGH 4'h5
`define OFF_FIRST_LATCH_LOW 4'h6
`define OFF_FIRST_LATCH_HIGH 4'h7
`define OFF_SECOND_COUNT_LOW 4'h8
`define OFF_SECOND_COUNT_HIGH 4'h9

// reset values
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_WAVE 1'b1

// width of each timer counter
`define COUNT_WIDTH 16

`endif

// ---- dual_interval_timer_pkg.sv ----
// state types of the dual interval timer
package dual_interval_timer_pkg;

	// whole state of the timer top, registered as one word
	typedef struct packed {
		logic [7:0] first_latch_low;   // low latch of the first timer
		logic [7:0] first_latch_high;  // high latch of the first timer
		logic first_run;               // first counter has been started
		logic first_armed;             // one-shot flag may still set
		logic first_flag;              // first timer interrupt flag
		logic wave;                    // level the timer puts on the wave pin
		logic [7:0] second_latch_low;  // write-only low latch of the second timer
		logic second_run;              // second counter has been started
		logic second_armed;            // second flag may still set
		logic second_flag;             // second timer interrupt flag
		logic pulse_prev;              // count pin level one cycle ago
		logic [7:0] read_data;         // byte returned to the processor
	} timer_state_type;

endpackage

// ---- dual_interval_timer_test.sv ----
// self-checking bench of the dual interval timer
`timescale 1ns/1ps
`include "dual_interval_timer_cfg.svh"
module dual_interval_timer_test;
	logic mclk; // system clock
	logic rst_n = 1'b0, wave_oe = 1'b0, free_run = 1'b0, pulse_mode = 1'b0; // controls
	logic pin_dir = 1'b0, pin_val = 1'b0, flag_clr = 1'b0, irq_en1 = 1'b1, irq_en2 = 1'b0, count_pin = 1'b1;
	logic [3:0] reg_select; // bus from the processor model
	logic access, read_sel;
	logic [7:0] wdata, rdata, got;
	logic wave_pin, wave_oe_n, irq_n, flag1, flag2; // timer outputs
	logic [15:0] seed = 16'h0031; // xorshift state, starts at 49
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int n, l1, l2;

	cpu_bus_model u_cpu (.i_mclk(mclk), .o_reg_select(reg_select), .o_access(access), .o_read(read_sel),
		.o_data(wdata), .i_data(rdata));

	dual_interval_timer u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_reg_select(reg_select), .i_access(access),
		.i_read(read_sel), .i_data(wdata), .o_data(rdata), .i_wave_output_enable(wave_oe),
		.i_free_run_enable(free_run), .i_second_pulse_mode(pulse_mode), .i_wave_pin_direction(pin_dir),
		.i_wave_pin_out_value(pin_val), .i_first_flag_clear(flag_clr), .i_first_irq_enable(irq_en1),
		.i_second_irq_enable(irq_en2), .i_pulse_count_pin(count_pin), .o_timer_wave_pin(wave_pin),
		.o_timer_wave_pin_oe_n(wave_oe_n), .o_interrupt_request_n(irq_n), .o_first_flag(flag1),
		.o_second_flag(flag2));

	// free-running clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// xorshift step of the random source
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction

	// level expected on the wave pin from the mux controls
	function automatic logic exp_pin(input logic oe, input logic wave, input logic port_bit);
		return oe ? wave : port_bit;
	endfunction

	// compare one value and count it
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// let k edges pass, then settle
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// counts and verdict, then stop
	task automatic final_report();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			final_report();
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		#1;
		check(rdata, 8'h00);
		check({flag1, flag2, irq_n, wave_oe_n}, 4'h3);
		@(posedge mclk);
		rst_n <= 1'b1;
		wave_oe <= 1'b1;
		// latch readback, unmapped code, low count address feeds the latch
		seed = next_rand(seed);
		u_cpu.wr(`OFF_FIRST_LATCH_LOW, seed[7:0]);
		u_cpu.wr(`OFF_FIRST_LATCH_HIGH, seed[15:8]);
		u_cpu.rd(`OFF_FIRST_LATCH_LOW, got);
		check(got, seed[7:0]);
		u_cpu.rd(`OFF_FIRST_LATCH_HIGH, got);
		check(got, seed[15:8]);
		u_cpu.rd(4'h0, got);
		check(got, 8'h00);
		u_cpu.wr(`OFF_FIRST_COUNT_LOW, ~seed[7:0]);
		u_cpu.rd(`OFF_FIRST_LATCH_LOW, got);
		check(got, {8'h00, ~seed[7:0]});
		// one-shot pulse with a high latch write mid-count
		n = 8 + int'(seed[2:0]);
		u_cpu.wr(`OFF_FIRST_LATCH_LOW, 8'(n));
		u_cpu.wr(`OFF_FIRST_COUNT_HIGH, 8'h00);
		step(0);
		check(wave_pin, 1'b0);
		step(1);
		u_cpu.wr(`OFF_FIRST_LATCH_HIGH, 8'h5a);
		step(n - 3);
		check({flag1, wave_pin}, 2'b00);
		step(1);
		check({flag1, wave_pin, irq_n}, 3'b110);
		// pin mux over every control combination
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			pin_dir <= i[0];
			wave_oe <= i[1];
			pin_val <= i[2];
			#1;
			check(wave_oe_n, !(i[0] | i[1]));
			check(wave_pin, exp_pin(i[1], 1'b1, i[2]));
		end
		// high write clears flag, a second write restarts the period
		u_cpu.wr(`OFF_FIRST_COUNT_HIGH, 8'h00);
		step(0);
		check(flag1, 1'b0);
		step(1);
		u_cpu.wr(`OFF_FIRST_COUNT_HIGH, 8'h00);
		step(n);
		check(flag1, 1'b0);
		step(1);
		check(flag1, 1'b1);
		// free run: toggles, reloads, three ways to clear
		@(posedge mclk);
		free_run <= 1'b1;
		seed = next_rand(seed);
		l1 = 6 + int'(seed[1:0]);
		l2 = 5 + int'(seed[3:2]);
		u_cpu.wr(`OFF_FIRST_LATCH_LOW, 8'(l1));
		u_cpu.wr(`OFF_FIRST_LATCH_HIGH, 8'h00);
		step(0);
		check(flag1, 1'b0);
		u_cpu.wr(`OFF_FIRST_COUNT_HIGH, 8'h00);
		step(l1);
		check(flag1, 1'b0);
		step(1);
		check({flag1, wave_pin}, 2'b11);
		@(posedge mclk);
		flag_clr <= 1'b1;
		@(posedge mclk);
		flag_clr <= 1'b0;
		#1;
		check(flag1, 1'b0);
		u_cpu.wr(`OFF_FIRST_LATCH_LOW, 8'(l2));
		step(l1 - 4);
		check(flag1, 1'b0);
		step(1);
		check({flag1, wave_pin}, 2'b10);
		u_cpu.rd(`OFF_FIRST_COUNT_LOW, got);
		check(got, 8'(l2 - 1));
		check(flag1, 1'b0);
		step(l2 - 3);
		check(flag1, 1'b0);
		step(1);
		check({flag1, wave_pin}, 2'b11);
		n = 4 + int'(seed[6:4]);
		u_cpu.wr(`OFF_SECOND_COUNT_LOW, 8'(n));
		u_cpu.wr(`OFF_SECOND_COUNT_HIGH, 8'h00);
		step(n);
		check(flag2, 1'b0);
		step(1);
		check(flag2, 1'b1);
		u_cpu.rd(`OFF_SECOND_COUNT_LOW, got);
		check(flag2, 1'b0);
		// pulse mode counts falling edges only
		@(posedge mclk);
		pulse_mode <= 1'b1;
		u_cpu.wr(`OFF_SECOND_COUNT_LOW, 8'h03);
		u_cpu.wr(`OFF_SECOND_COUNT_HIGH, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			count_pin <= 1'b0;
			@(posedge mclk);
			count_pin <= 1'b1;
			step(3);
			if (k == 2)
				check(flag2, 1'b0);
		end
		check(flag2, 1'b1);
		final_report();
	end
endmodule
